// file: src/srq_regs.sv
// Distribution sync control, self-clearing reset strobes and IRQ clearing registers.
// Assumes an APB master on i_clk; all strobe consumers and the watchdog period
// source sit in the same clock domain.
`timescale 1ns/100ps

module srq_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [15:0]           i_paddr,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [3:0]            i_pstrb,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic [15:0]           i_wdog_period,
  output logic                       o_dist_stall,
  output logic                       o_dist_sync_start,
  output logic                       o_dist_restart,
  output logic                       o_loop_filter_wipe,
  output logic                       o_comb_filter_wipe,
  output logic                       o_auto_sync_reset,
  output logic                       o_frequency_word_history_reset,
  output logic                       o_interrupt_flags_wipe_all,
  output logic                       o_wdog_timeout,
  output logic      [5:0]            o_irq_clr_clock,
  output logic      [4:0]            o_irq_clr_misc
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire        sel_sync   = (i_paddr == srq_pkg::ADDR_SYNC_CTRL);
  wire        sel_rst    = (i_paddr == srq_pkg::ADDR_RST_STROBES);
  wire        sel_clk    = (i_paddr == srq_pkg::ADDR_IRQ_CLR_CLK);
  wire        sel_misc   = (i_paddr == srq_pkg::ADDR_IRQ_CLR_MISC);
  wire        mapped     = sel_sync | sel_rst | sel_clk | sel_misc;
  wire        access     = i_psel & i_penable;
  wire        setup      = i_psel & ~i_penable;
  // Only byte lane 0 carries data; a write with lane 0 disabled changes nothing
  wire        wr_en      = access & i_pwrite & mapped & i_pstrb[0];
  wire [7:0]  wbyte      = i_pwdata[7:0];
  wire        wr_rst     = wr_en & sel_rst;

  logic [7:0]  sync_q;
  logic [7:0]  sync_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // Zero wait states: every access completes in its first access cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = access & ~mapped;

  // Strobe registers read back zero; only sync control holds state
  assign prdata_d  = (setup & ~i_pwrite & sel_sync) ? {24'h0, sync_q} : 32'h0;

  // ************************************************************
  // Distribution sync control
  // ************************************************************
  // Only the soft sync bit is writable; the rest stay at reset value
  assign sync_d = (wr_en & sel_sync) ?
                  ((wbyte & srq_pkg::SYNC_CTRL_WMASK) |
                   (srq_pkg::SYNC_CTRL_RESET & ~srq_pkg::SYNC_CTRL_WMASK)) : sync_q;

  wire soft_now  = sync_q[srq_pkg::SYNC_SOFT_BIT];
  wire soft_next = sync_d[srq_pkg::SYNC_SOFT_BIT];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_q   <= srq_pkg::SYNC_CTRL_RESET;
      prdata_q <= 32'h0;
    end else begin
      sync_q   <= sync_d;
      prdata_q <= prdata_d;
    end
  end

  assign o_prdata     = prdata_q;
  // Stall tracks the stored bit so outputs hold as long as it reads one
  assign o_dist_stall = soft_now;

  logic start_q;
  logic restart_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      start_q   <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      start_q   <= ~soft_now & soft_next;
      restart_q <= soft_now & ~soft_next;
    end
  end
  assign o_dist_sync_start = start_q;
  assign o_dist_restart    = restart_q;

  // ************************************************************
  // Self-clearing strobes
  // ************************************************************
  // Each strobe lives for one cycle after the write; nothing needs a zero write
  wire [7:0] rst_d  = wr_rst ? wbyte : 8'h00;
  wire       wipe_d = rst_d[srq_pkg::RST_WIPE_ALL];

  // Wipe all ORs a full set of ones into every clearing lane
  wire [5:0] clk_d  = ((wr_en & sel_clk) ? wbyte[5:0] : 6'h00) |
                      (wipe_d ? srq_pkg::CLR_CLK_ALL : 6'h00);
  wire [4:0] misc_d = ((wr_en & sel_misc) ? wbyte[4:0] : 5'h00) |
                      (wipe_d ? srq_pkg::CLR_MISC_ALL : 5'h00);

  logic [7:0] rst_q;
  logic [5:0] clk_q;
  logic [4:0] misc_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q  <= 8'h00;
      clk_q  <= 6'h00;
      misc_q <= 5'h00;
    end else begin
      rst_q  <= rst_d;
      clk_q  <= clk_d;
      misc_q <= misc_d;
    end
  end

  assign o_loop_filter_wipe             = rst_q[srq_pkg::RST_LOOP_FILTER];
  assign o_comb_filter_wipe             = rst_q[srq_pkg::RST_COMB_FILTER];
  assign o_auto_sync_reset              = rst_q[srq_pkg::RST_AUTO_SYNC];
  assign o_frequency_word_history_reset = rst_q[srq_pkg::RST_FW_HISTORY];
  assign o_interrupt_flags_wipe_all     = rst_q[srq_pkg::RST_WIPE_ALL];
  assign o_irq_clr_clock                = clk_q;
  assign o_irq_clr_misc                 = misc_q;

  // ************************************************************
  // Watchdog timer
  // ************************************************************
  // Counts clock cycles; a period of zero disables it. A kick wins over an
  // expiry in the same cycle, which is what lets software suppress timeouts.
  wire        kick     = rst_q[srq_pkg::RST_WDOG];
  logic [15:0] wcnt_q;
  logic        tmo_q;
  wire        wdog_on  = (i_wdog_period != 16'h0000);
  wire        expire   = wdog_on & (wcnt_q == (i_wdog_period - 16'h0001));
  wire        tmo_d    = expire & ~kick;
  wire [15:0] wcnt_d   = (kick | expire | ~wdog_on) ? srq_pkg::WDOG_CNT_RESET :
                         (wcnt_q + 16'h0001);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wcnt_q <= srq_pkg::WDOG_CNT_RESET;
      tmo_q  <= 1'b0;
    end else begin
      wcnt_q <= wcnt_d;
      tmo_q  <= tmo_d;
    end
  end
  assign o_wdog_timeout = tmo_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_stall_tracks_bit: assert property (o_dist_stall == sync_q[1])
    else $error("stall does not follow soft sync bit");
  a_restart_on_fall: assert property ($fell(o_dist_stall) |-> o_dist_restart)
    else $error("no restart on soft sync falling edge");
  a_no_restart_set: assert property ($rose(o_dist_stall) |-> !o_dist_restart && o_dist_sync_start)
    else $error("sync start or restart wrong on rising edge");
  a_sync_reserved_zero: assert property ((sync_q & 8'hfd) == 8'h00)
    else $error("reserved sync control bits not zero");
  a_lf_pulse_once: assert property (wr_rst && i_pwdata[6] |=> o_loop_filter_wipe ##1 !o_loop_filter_wipe)
    else $error("loop filter wipe not a single pulse");
  a_cci_pulse_once: assert property (wr_rst && i_pwdata[5] |=> o_comb_filter_wipe ##1 !o_comb_filter_wipe)
    else $error("comb filter wipe not a single pulse");
  a_strobe_zero_write: assert property (wr_rst && !i_pwdata[3] && !i_pwdata[2] |=> !o_auto_sync_reset && !o_frequency_word_history_reset)
    else $error("strobe fired on zero write");
  a_wipe_all_lanes: assert property (o_interrupt_flags_wipe_all |-> o_irq_clr_clock == 6'h3f && o_irq_clr_misc == 5'h1f)
    else $error("wipe all did not clear every lane");
  a_clk_map: assert property (wr_en && sel_clk && !wipe_d |=> o_irq_clr_clock == $past(i_pwdata[5:0]) ##1 o_irq_clr_clock == 6'h00)
    else $error("clock status clear mapping wrong");
  a_misc_map: assert property (wr_en && sel_misc && !wipe_d |=> o_irq_clr_misc == $past(i_pwdata[4:0]) ##1 o_irq_clr_misc == 5'h00)
    else $error("misc clear mapping wrong");
  a_kick_restart: assert property (kick |=> wcnt_q == 16'h0000 && !o_wdog_timeout)
    else $error("kick did not restart watchdog quietly");
  a_timeout_fresh: assert property (o_wdog_timeout |-> wcnt_q == 16'h0000 ##1 (wcnt_q == 16'h0001 || $past(kick) || i_wdog_period == 16'h0001))
    else $error("watchdog did not start fresh cycle");
  a_read_strobe_zero: assert property (access && !i_pwrite && !sel_sync |-> o_prdata == 32'h0)
    else $error("non-storing register read non-zero");

  c_soft_sync_cycle: cover property ($rose(o_dist_stall) ##[1:20] o_dist_restart);
  c_wipe_all: cover property (o_interrupt_flags_wipe_all);
  c_wdog_timeout: cover property (o_wdog_timeout);
  c_kick_at_expiry: cover property (kick && expire);
  c_kick_twice: cover property (kick ##[1:10] kick);

  // ************************************************************
  // Sync control checks
  // ************************************************************
  // Start and restart must each follow one direction of the bit only
  a_start_after_set: assert property (
    wr_en && sel_sync && wbyte[1] && !soft_now |=> o_dist_sync_start && o_dist_stall)
    else $error("no sync start after soft sync set");

  a_start_only_rise: assert property (
    o_dist_sync_start |-> $rose(o_dist_stall))
    else $error("sync start without rising soft sync bit");

  a_read_sync_value: assert property (
    access && !i_pwrite && sel_sync |-> o_prdata[1] == soft_now)
    else $error("soft sync bit reads back wrong");

  a_stall_hold: assert property (
    !(wr_en && sel_sync) |=> $stable(o_dist_stall))
    else $error("stall moved without a sync write");

  a_stall_set_write: assert property (
    wr_en && sel_sync |=> o_dist_stall == $past(wbyte[1]))
    else $error("stall does not follow written bit");

  a_restart_only_fall: assert property (
    o_dist_restart |-> $fell(o_dist_stall))
    else $error("restart without falling soft sync bit");

  a_restart_after_clear: assert property (
    wr_en && sel_sync && !wbyte[1] && soft_now |=> o_dist_restart)
    else $error("no restart after soft sync clear");

  a_no_start_and_restart: assert property (
    !(o_dist_sync_start && o_dist_restart))
    else $error("start and restart in one cycle");

  a_sync_read_mask: assert property (
    access && !i_pwrite && sel_sync |-> o_prdata[31:2] == 30'h0 && !o_prdata[0])
    else $error("reserved sync bits read non-zero");

  // ************************************************************
  // Strobe checks
  // ************************************************************
  // Every strobe needs a one written in its own lane, and nothing else
  a_lf_only_write: assert property (
    o_loop_filter_wipe |-> $past(wr_rst && wbyte[6]))
    else $error("loop filter wipe without write");

  a_cci_only_write: assert property (
    o_comb_filter_wipe |-> $past(wr_rst && wbyte[5]))
    else $error("comb filter wipe without write");

  a_auto_sync_pulse: assert property (
    wr_rst && wbyte[3] |=> o_auto_sync_reset ##1 !o_auto_sync_reset)
    else $error("auto sync reset not a single pulse");

  a_history_pulse: assert property (
    wr_rst && wbyte[2] |=> o_frequency_word_history_reset ##1 !o_frequency_word_history_reset)
    else $error("history reset not a single pulse");

  a_wipe_pulse: assert property (
    wr_rst && wbyte[1] |=> o_interrupt_flags_wipe_all ##1 !o_interrupt_flags_wipe_all)
    else $error("wipe all not a single pulse");

  a_wipe_no_write: assert property (
    o_interrupt_flags_wipe_all |-> $past(wr_rst && wbyte[1]))
    else $error("wipe all without write");

  a_lf_zero_write: assert property (
    wr_rst && !wbyte[6] |=> !o_loop_filter_wipe)
    else $error("loop filter wipe on zero write");

  a_cci_zero_write: assert property (
    wr_rst && !wbyte[5] |=> !o_comb_filter_wipe)
    else $error("comb filter wipe on zero write");

  a_wipe_zero_write: assert property (
    wr_rst && !wbyte[1] |=> !o_interrupt_flags_wipe_all)
    else $error("wipe all on zero write");

  a_kick_zero_write: assert property (
    wr_rst && !wbyte[0] |=> !kick)
    else $error("watchdog kick on zero write");

  // ************************************************************
  // Watchdog checks
  // ************************************************************
  // The count wraps in 16 bits, so the step is compared at that width
  a_kick_pulse: assert property (
    wr_rst && wbyte[0] |=> kick ##1 wcnt_q == srq_pkg::WDOG_CNT_RESET)
    else $error("kick write did not clear watchdog");

  a_kick_only_write: assert property (
    kick |-> $past(wr_rst && wbyte[0]))
    else $error("watchdog kick without write");

  a_wdog_idle_off: assert property (
    !wdog_on |=> wcnt_q == srq_pkg::WDOG_CNT_RESET && !o_wdog_timeout)
    else $error("disabled watchdog still counting");

  a_timeout_at_expiry: assert property (
    expire && !kick |=> o_wdog_timeout)
    else $error("no timeout at expiry");

  a_timeout_only_expiry: assert property (
    o_wdog_timeout |-> $past(expire))
    else $error("timeout without expiry");

  a_no_timeout_kick: assert property (
    kick |=> !o_wdog_timeout)
    else $error("timeout right after kick");

  a_count_step: assert property (
    wdog_on && !kick && !expire |=> wcnt_q == 16'($past(wcnt_q) + 16'h0001))
    else $error("watchdog count did not step");

  // ************************************************************
  // Clearing lane and bus checks
  // ************************************************************
  // Legal transfers never strike on two edges in a row, so a lane must drop
  a_clk_only_write: assert property (
    o_irq_clr_clock != 6'h00 |-> $past((wr_en && sel_clk) || wipe_d))
    else $error("clock status clear without write");

  a_misc_only_write: assert property (
    o_irq_clr_misc != 5'h00 |-> $past((wr_en && sel_misc) || wipe_d))
    else $error("misc clear without write");

  a_clk_pulse_clear: assert property (
    o_irq_clr_clock != 6'h00 |=> o_irq_clr_clock == 6'h00)
    else $error("clock status clear did not self clear");

  a_misc_pulse_clear: assert property (
    o_irq_clr_misc != 5'h00 |=> o_irq_clr_misc == 5'h00)
    else $error("misc clear did not self clear");

  a_clk_zero_write: assert property (
    wr_en && sel_clk |=> (o_irq_clr_clock & ~$past(wbyte[5:0])) == 6'h00)
    else $error("clock status lane fired on zero bit");

  a_misc_zero_write: assert property (
    wr_en && sel_misc |=> (o_irq_clr_misc & ~$past(wbyte[4:0])) == 5'h00)
    else $error("misc lane fired on zero bit");

  a_slverr_unmapped: assert property (
    access && !mapped |-> o_pslverr)
    else $error("no error on unmapped access");

  a_slverr_mapped: assert property (
    mapped |-> !o_pslverr)
    else $error("error on mapped access");

  a_unmapped_no_effect: assert property (
    access && i_pwrite && !mapped |=>
      $stable(o_dist_stall) && rst_q == 8'h00 && clk_q == 6'h00 && misc_q == 5'h00)
    else $error("unmapped write had an effect");

  a_lane_off_no_effect: assert property (
    access && i_pwrite && !i_pstrb[0] |=>
      $stable(o_dist_stall) && rst_q == 8'h00 && clk_q == 6'h00 && misc_q == 5'h00)
    else $error("write with lane 0 off had an effect");

endmodule // srq_regs

// file: inc/srq_pkg.sv
// Constants for the distribution sync, reset strobe and IRQ clearing register group.
// Assumes an APB slave with 32-bit data; each register takes one aligned word.
package srq_pkg;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam int unsigned    ADDR_W           = 16;
  localparam logic [11:0]    IDX_SYNC_CTRL    = 12'ha02;
  localparam logic [11:0]    IDX_RST_STROBES  = 12'ha03;
  localparam logic [11:0]    IDX_IRQ_CLR_CLK  = 12'ha04;
  localparam logic [11:0]    IDX_IRQ_CLR_MISC = 12'ha05;
  // Byte address is four times the index
  localparam logic [15:0]    ADDR_SYNC_CTRL    = {2'h0, IDX_SYNC_CTRL, 2'h0};
  localparam logic [15:0]    ADDR_RST_STROBES  = {2'h0, IDX_RST_STROBES, 2'h0};
  localparam logic [15:0]    ADDR_IRQ_CLR_CLK  = {2'h0, IDX_IRQ_CLR_CLK, 2'h0};
  localparam logic [15:0]    ADDR_IRQ_CLR_MISC = {2'h0, IDX_IRQ_CLR_MISC, 2'h0};

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam logic [7:0]     SYNC_CTRL_RESET  = 8'h00;
  localparam logic [7:0]     SYNC_CTRL_WMASK  = 8'h02;
  localparam int unsigned    SYNC_SOFT_BIT    = 1;

  localparam int unsigned    RST_LOOP_FILTER  = 6;
  localparam int unsigned    RST_COMB_FILTER  = 5;
  localparam int unsigned    RST_AUTO_SYNC    = 3;
  localparam int unsigned    RST_FW_HISTORY   = 2;
  localparam int unsigned    RST_WIPE_ALL     = 1;
  localparam int unsigned    RST_WDOG         = 0;

  // Clock status clearing: 5 ref clk unlocked, 4 locked, 3 loop unlocked,
  // 2 loop locked, 1 calibration done, 0 calibration begun
  localparam int unsigned    CLR_CLK_W        = 6;
  localparam logic [5:0]     CLR_CLK_ALL      = 6'h3f;
  // Misc clearing: 4 pin program end, 3 dist sync, 2 watchdog, 1 nvm fault, 0 nvm done
  localparam int unsigned    CLR_MISC_W       = 5;
  localparam logic [4:0]     CLR_MISC_ALL     = 5'h1f;

  localparam int unsigned    WDOG_W           = 16;
  localparam logic [15:0]    WDOG_CNT_RESET   = 16'h0000;

endpackage : srq_pkg

// file: dv/srq_regs_tb_top.sv
// Self-checking bench for the sync control, reset strobe and IRQ clearing registers.
// Assumes srq_regs and srq_pkg are compiled first; the bench is the only APB master.
`timescale 1ns/100ps
module srq_regs_tb_top;
  // ************************************************************
  // Signals and instance
  // ************************************************************
  localparam logic [15:0] WP = 16'h0014;
  logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
  logic [15:0] i_paddr, i_wdog_period;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic [3:0]  i_pstrb, strb;
  logic        o_dist_stall, o_dist_sync_start, o_dist_restart, o_wdog_timeout, err;
  logic        o_loop_filter_wipe, o_comb_filter_wipe, o_auto_sync_reset;
  logic        o_frequency_word_history_reset, o_interrupt_flags_wipe_all;
  logic [5:0]  o_irq_clr_clock;
  logic [4:0]  o_irq_clr_misc;
  logic [15:0] adr;
  logic [7:0]  d;
  logic [15:0] strobe_adr [3];
  int          miscompares, cmp_count, seed, n, to_cnt, to_base;

  srq_regs srq_regs_i (.i_clk, .i_rst_n, .i_paddr, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
    .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_wdog_period, .o_dist_stall,
    .o_dist_sync_start, .o_dist_restart, .o_loop_filter_wipe, .o_comb_filter_wipe,
    .o_auto_sync_reset, .o_frequency_word_history_reset, .o_interrupt_flags_wipe_all,
    .o_wdog_timeout, .o_irq_clr_clock, .o_irq_clr_misc);

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_wdog_timeout === 1'b1) to_cnt++;

  // ************************************************************
  // Tasks and expectation functions
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high; waits are bounded
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a;
    i_pwdata <= wd; i_pstrb <= s;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin @(posedge i_clk); k++; end while (o_pready !== 1'b1 && k < 50);
    if (o_pready !== 1'b1) chk(32'h1, 32'h0);
    r = o_prdata; e = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask

  task automatic cnt_to(output int k);
    k = 0;
    do begin @(posedge i_clk); #1; k++; end while (o_wdog_timeout !== 1'b1 && k < 1000);
  endtask

  // Packs all strobe pulses: five reset strobes, clock clears, misc clears
  function automatic logic [31:0] exp_p(input logic [15:0] a, input logic [7:0] v);
    if (a == srq_pkg::ADDR_RST_STROBES)
      return {16'h0, v[6], v[5], v[3], v[2], v[1], {6{v[1]}}, {5{v[1]}}};
    if (a == srq_pkg::ADDR_IRQ_CLR_CLK) return {16'h0, 5'h0, v[5:0], 5'h0};
    if (a == srq_pkg::ADDR_IRQ_CLR_MISC) return {16'h0, 11'h0, v[4:0]};
    return 32'h0;
  endfunction

  task automatic give_verdict;
    $display("Counts: %0d comparisons, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    i_clk = 0; i_rst_n = 0; i_paddr = 0; i_psel = 0; i_penable = 0; i_pwrite = 0;
    i_pwdata = 0; i_pstrb = 4'hf; i_wdog_period = 0; seed = 32'hddaf;
    miscompares = 0; cmp_count = 0; to_cnt = 0;
    strobe_adr = '{srq_pkg::ADDR_RST_STROBES, srq_pkg::ADDR_IRQ_CLR_CLK,
                   srq_pkg::ADDR_IRQ_CLR_MISC};
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(1'b0, srq_pkg::ADDR_SYNC_CTRL, 32'h0, 4'hf, rdat, err);
    chk(rdat, 32'h0);
    apb(1'b0, 16'h0100, 32'h0, 4'hf, rdat, err);
    chk(32'({err, rdat[7:0]}), 32'h100);
    $display("Test reset values done");
    // Sync: stall follows the bit, restart only on the falling write
    apb(1'b1, srq_pkg::ADDR_SYNC_CTRL, 32'h2, 4'hf, rdat, err); #1;
    chk(32'({o_dist_stall, o_dist_sync_start, o_dist_restart}), 32'h6);
    apb(1'b1, srq_pkg::ADDR_SYNC_CTRL, 32'hff, 4'hf, rdat, err); #1;
    chk(32'({o_dist_stall, o_dist_sync_start, o_dist_restart}), 32'h4);
    apb(1'b0, srq_pkg::ADDR_SYNC_CTRL, 32'h0, 4'hf, rdat, err);
    chk(rdat, 32'h2);
    apb(1'b1, srq_pkg::ADDR_SYNC_CTRL, 32'h0, 4'hf, rdat, err); #1;
    chk(32'({o_dist_stall, o_dist_sync_start, o_dist_restart}), 32'h1);
    $display("Test soft sync done");
    // Every bit of each strobe register, then random bytes and byte strobes
    for (int i = 0; i < 48; i++) begin
      adr = strobe_adr[i % 3];
      d = (i < 24) ? 8'h01 << (i / 3) : 8'($random(seed));
      strb = (i < 24) ? 4'hf : 4'($random(seed));
      apb(1'b1, adr, {24'($random(seed)), d}, strb, rdat, err); #1;
      chk({16'h0, o_loop_filter_wipe, o_comb_filter_wipe, o_auto_sync_reset,
           o_frequency_word_history_reset, o_interrupt_flags_wipe_all, o_irq_clr_clock,
           o_irq_clr_misc}, strb[0] ? exp_p(adr, d) : 32'h0);
      @(posedge i_clk); #1;
      chk({o_loop_filter_wipe, o_comb_filter_wipe, o_auto_sync_reset, o_irq_clr_clock,
           o_frequency_word_history_reset, o_interrupt_flags_wipe_all, o_irq_clr_misc},
          32'h0);
      apb(1'b0, adr, 32'h0, 4'hf, rdat, err);
      chk(rdat, 32'h0);
      chk(32'(err), 32'h0);
    end
    $display("Test strobes and clears done");
    // Watchdog: free period, early kick, repeated kicks
    @(posedge i_clk);
    i_wdog_period <= WP;
    cnt_to(n);
    cnt_to(n);
    chk(32'(n), 32'(WP));
    repeat (4) @(posedge i_clk);
    apb(1'b1, srq_pkg::ADDR_RST_STROBES, 32'h1, 4'hf, rdat, err);
    cnt_to(n);
    chk(32'(n), 32'(WP) + 32'h1);
    // Let the counter take the timeout just seen before the baseline is read
    @(posedge i_clk); #1;
    to_base = to_cnt;
    // Kicks spaced well inside the period keep the timer quiet
    repeat (6) begin
      apb(1'b1, srq_pkg::ADDR_RST_STROBES, 32'h1, 4'hf, rdat, err);
      repeat (5) @(posedge i_clk);
    end
    chk(32'(to_cnt - to_base), 32'h0);
    $display("Test watchdog done");
    give_verdict();
  end

  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule // srq_regs_tb_top
